// ---- core/monitor_pkg.sv ----
// Constants, register map and encodings for the monitor output generator
package monitor_pkg;
   // Clock and timing
   localparam int CLK_MHZ = 100;
   localparam int PWM_STEP_NS = 100;
   localparam int PWM_STEP_CYCLES = (PWM_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int PWM_BITS = 10;
   localparam logic [10:0] FRAC_FULL = 11'h400;
   localparam int GAIN_SHIFT = 7;
   localparam int FRAC_SHIFT = 10;
   // FM phase increment per cycle: 2^48 / 1e9, applied as (code * K) >> 16
   localparam logic [18:0] FM_INC_K = 19'h4_4B83;
   localparam int FM_INC_SHIFT = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_PULSE_SEL = 8'h00;
   localparam logic [7:0] OFS_PULSE_GAIN = 8'h04;
   localparam logic [7:0] OFS_MAX_FREQ = 8'h08;
   localparam logic [7:0] OFS_VOLT_SEL = 8'h0C;
   localparam logic [7:0] OFS_CURR_SEL = 8'h10;
   localparam logic [7:0] OFS_VOLT_GAIN = 8'h14;
   localparam logic [7:0] OFS_VOLT_OFS = 8'h18;
   localparam logic [7:0] OFS_CURR_GAIN = 8'h1C;
   localparam logic [7:0] OFS_CURR_OFS = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_LEVELS = 8'h28;

   // Reset values
   localparam logic [7:0] RST_PULSE_SEL = 8'h00;
   localparam logic [7:0] RST_PULSE_GAIN = 8'h80;
   localparam logic [15:0] RST_MAX_FREQ = 16'h1770;
   localparam logic [7:0] RST_VOLT_SEL = 8'h00;
   localparam logic [7:0] RST_CURR_SEL = 8'h00;
   localparam logic [7:0] RST_VOLT_GAIN = 8'hB4;
   localparam logic [7:0] RST_VOLT_OFS = 8'h00;
   localparam logic [7:0] RST_CURR_GAIN = 8'h50;
   localparam logic [7:0] RST_CURR_OFS = 8'h00;

   // Source select codes
   localparam logic [7:0] SRC_OUT_FREQ = 8'h00;
   localparam logic [7:0] SRC_OUT_CURR = 8'h01;
   localparam logic [7:0] SRC_OUT_FREQ_FM = 8'h03;
   localparam logic [7:0] SRC_OUT_VOLT = 8'h04;
   localparam logic [7:0] SRC_IN_POWER = 8'h05;
   localparam logic [7:0] SRC_THERMAL = 8'h06;
   localparam logic [7:0] SRC_RAMP_FREQ = 8'h07;

   // Full scales in input units (0.1 percent); frequencies use max_frequency_setting
   localparam logic [15:0] FS_PCT_200 = 16'h07D0;
   localparam logic [15:0] FS_PCT_100 = 16'h03E8;

   // Analog levels: voltage in 0.01 V, current in 0.01 mA, offsets in 0.1 units
   localparam logic [10:0] VOLT_SPAN = 11'h3E8;
   localparam logic [10:0] VOLT_MAX = 11'h3E8;
   localparam logic [7:0] VOLT_OFS_MAX = 8'h64;
   localparam logic [11:0] CURR_BASE = 12'h190;
   localparam logic [10:0] CURR_SPAN = 11'h640;
   localparam logic [11:0] CURR_MAX = 12'h7D0;
   localparam logic [7:0] CURR_OFS_MAX = 8'hC8;

   typedef enum logic [1:0] {
      SEQ_START = 2'b01,
      SEQ_WAIT = 2'b10
   } seq_state_t;
endpackage

// ---- core/fraction_divider.sv ----
// Sequential divider giving num/den as a saturated Q10 fraction
`timescale 1ns/100ps
module fraction_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [15:0] num,
   input wire logic [15:0] den,
   output logic done,
   output logic [10:0] frac
);
   logic [16:0] rem_q;
   logic [15:0] den_q;
   logic [9:0] quo_q;
   logic [3:0] step_q;
   logic busy_q;
   logic [16:0] shifted;

   assign shifted = {rem_q[15:0], 1'b0};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_q <= 17'h0_0000;
         den_q <= 16'h0000;
         quo_q <= 10'h000;
         step_q <= 4'h0;
         busy_q <= 1'b0;
         done <= 1'b0;
         frac <= 11'h000;
      end else begin
         done <= 1'b0;
         if (start) begin
            // Zero full scale reads as zero rather than dividing by zero
            if (den == 16'h0000) begin
               frac <= 11'h000;
               done <= 1'b1;
            end else if (num >= den) begin
               frac <= monitor_pkg::FRAC_FULL;
               done <= 1'b1;
            end else begin
               rem_q <= {1'b0, num};
               den_q <= den;
               quo_q <= 10'h000;
               step_q <= 4'h0;
               busy_q <= 1'b1;
            end
         end else if (busy_q) begin
            if (shifted >= {1'b0, den_q}) begin
               rem_q <= shifted - {1'b0, den_q};
               quo_q <= {quo_q[8:0], 1'b1};
            end else begin
               rem_q <= shifted;
               quo_q <= {quo_q[8:0], 1'b0};
            end
            step_q <= step_q + 4'h1;
            if (step_q == 4'h9) begin
               busy_q <= 1'b0;
               done <= 1'b1;
               frac <= {1'b0, quo_q[8:0], (shifted >= {1'b0, den_q})};
            end
         end
      end
   end
endmodule

// ---- core/monitor_output_generator.sv ----
// Pulse, voltage and current monitor outputs with APB register access
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module monitor_output_generator (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] output_frequency,
   input wire logic [15:0] output_current,
   input wire logic [15:0] output_voltage,
   input wire logic [15:0] input_power,
   input wire logic [15:0] thermal_load,
   input wire logic [15:0] ramped_frequency,
   output logic pulse_monitor_pin,
   output logic [10:0] voltage_monitor_pin,
   output logic [11:0] current_monitor_pin
);
   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] pulse_output_source_select_q;
   logic [7:0] pulse_output_gain_q;
   logic [15:0] max_frequency_setting_q;
   logic [7:0] voltage_output_source_select_q;
   logic [7:0] current_output_source_select_q;
   logic [7:0] voltage_output_gain_q;
   logic [7:0] voltage_output_offset_q;
   logic [7:0] current_output_gain_q;
   logic [7:0] current_output_offset_q;

   logic access;
   logic mapped;
   logic [10:0] duty_q;
   logic [31:0] rd_word;

   assign access = psel && penable;
   assign pready = 1'b1;

   always_comb begin
      mapped = 1'b1;
      rd_word = 32'h0000_0000;
      case (paddr)
         monitor_pkg::OFS_PULSE_SEL: rd_word = {24'h00_0000, pulse_output_source_select_q};
         monitor_pkg::OFS_PULSE_GAIN: rd_word = {24'h00_0000, pulse_output_gain_q};
         monitor_pkg::OFS_MAX_FREQ: rd_word = {16'h0000, max_frequency_setting_q};
         monitor_pkg::OFS_VOLT_SEL: rd_word = {24'h00_0000, voltage_output_source_select_q};
         monitor_pkg::OFS_CURR_SEL: rd_word = {24'h00_0000, current_output_source_select_q};
         monitor_pkg::OFS_VOLT_GAIN: rd_word = {24'h00_0000, voltage_output_gain_q};
         monitor_pkg::OFS_VOLT_OFS: rd_word = {24'h00_0000, voltage_output_offset_q};
         monitor_pkg::OFS_CURR_GAIN: rd_word = {24'h00_0000, current_output_gain_q};
         monitor_pkg::OFS_CURR_OFS: rd_word = {24'h00_0000, current_output_offset_q};
         monitor_pkg::OFS_STATUS: rd_word = {15'h0000, pulse_monitor_pin, 5'h00, duty_q};
         monitor_pkg::OFS_LEVELS: rd_word = {4'h0, current_monitor_pin, 5'h00, voltage_monitor_pin};
         default: mapped = 1'b0;
      endcase
      if (!psel || pwrite || !mapped) begin
         rd_word = 32'h0000_0000;
      end
   end

   // Latched at setup, so read data leaves a flop and stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_word;
      end
   end

   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_output_source_select_q <= monitor_pkg::RST_PULSE_SEL;
         pulse_output_gain_q <= monitor_pkg::RST_PULSE_GAIN;
         max_frequency_setting_q <= monitor_pkg::RST_MAX_FREQ;
         voltage_output_source_select_q <= monitor_pkg::RST_VOLT_SEL;
         current_output_source_select_q <= monitor_pkg::RST_CURR_SEL;
         voltage_output_gain_q <= monitor_pkg::RST_VOLT_GAIN;
         voltage_output_offset_q <= monitor_pkg::RST_VOLT_OFS;
         current_output_gain_q <= monitor_pkg::RST_CURR_GAIN;
         current_output_offset_q <= monitor_pkg::RST_CURR_OFS;
      end else if (access && pwrite) begin
         case (paddr)
            monitor_pkg::OFS_PULSE_SEL: pulse_output_source_select_q <= pwdata[7:0];
            monitor_pkg::OFS_PULSE_GAIN: pulse_output_gain_q <= pwdata[7:0];
            monitor_pkg::OFS_MAX_FREQ: max_frequency_setting_q <= pwdata[15:0];
            monitor_pkg::OFS_VOLT_SEL: voltage_output_source_select_q <= pwdata[7:0];
            monitor_pkg::OFS_CURR_SEL: current_output_source_select_q <= pwdata[7:0];
            monitor_pkg::OFS_VOLT_GAIN: voltage_output_gain_q <= pwdata[7:0];
            // Offsets beyond their range are clipped on write
            monitor_pkg::OFS_VOLT_OFS: voltage_output_offset_q <= (pwdata[7:0] > monitor_pkg::VOLT_OFS_MAX) ?
               monitor_pkg::VOLT_OFS_MAX : pwdata[7:0];
            monitor_pkg::OFS_CURR_GAIN: current_output_gain_q <= pwdata[7:0];
            monitor_pkg::OFS_CURR_OFS: current_output_offset_q <= (pwdata[7:0] > monitor_pkg::CURR_OFS_MAX) ?
               monitor_pkg::CURR_OFS_MAX : pwdata[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Quantity selection and normalisation
   function automatic logic [11:0] gain_scale(input logic [10:0] frac, input logic [7:0] gain);
      logic [18:0] prod;
      prod = 19'(frac) * 19'(gain);
      prod = prod >> monitor_pkg::GAIN_SHIFT;
      gain_scale = (prod >= 19'(monitor_pkg::FRAC_FULL)) ? 12'(monitor_pkg::FRAC_FULL) : prod[11:0];
   endfunction

   function automatic logic [11:0] span_scale(input logic [10:0] frac, input logic [7:0] gain,
                                              input logic [10:0] span);
      logic [29:0] prod;
      prod = 30'(frac) * 30'(gain) * 30'(span);
      prod = prod >> (monitor_pkg::GAIN_SHIFT + monitor_pkg::FRAC_SHIFT);
      span_scale = (prod > 30'h0000_0FFF) ? 12'hFFF : prod[11:0];
   endfunction

   monitor_pkg::seq_state_t seq_q;
   logic [1:0] ch_q;
   logic [7:0] ch_code;
   logic [15:0] ch_num;
   logic [15:0] ch_den;
   logic div_start;
   logic div_done;
   logic [10:0] div_frac;
   logic [10:0] frac_q [0:2];

   always_comb begin
      case (ch_q)
         2'd1: ch_code = voltage_output_source_select_q;
         2'd2: ch_code = current_output_source_select_q;
         default: ch_code = pulse_output_source_select_q;
      endcase
      ch_num = 16'h0000;
      ch_den = 16'h0000;
      case (ch_code)
         monitor_pkg::SRC_OUT_FREQ: begin
            ch_num = output_frequency;
            ch_den = max_frequency_setting_q;
         end
         monitor_pkg::SRC_OUT_CURR: begin
            ch_num = output_current;
            ch_den = monitor_pkg::FS_PCT_200;
         end
         monitor_pkg::SRC_OUT_VOLT: begin
            ch_num = output_voltage;
            ch_den = monitor_pkg::FS_PCT_100;
         end
         monitor_pkg::SRC_IN_POWER: begin
            ch_num = input_power;
            ch_den = monitor_pkg::FS_PCT_200;
         end
         monitor_pkg::SRC_THERMAL: begin
            ch_num = thermal_load;
            ch_den = monitor_pkg::FS_PCT_100;
         end
         monitor_pkg::SRC_RAMP_FREQ: begin
            ch_num = ramped_frequency;
            ch_den = max_frequency_setting_q;
         end
         // Unlisted codes, and FM for the analog channels, read as zero
         default: ;
      endcase
   end

   assign div_start = (seq_q == monitor_pkg::SEQ_START);

   // One shared divider is time-multiplexed over the three channels
   fraction_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .num(ch_num),
      .den(ch_den),
      .done(div_done),
      .frac(div_frac)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_q <= monitor_pkg::SEQ_START;
         ch_q <= 2'd0;
      end else begin
         case (seq_q)
            monitor_pkg::SEQ_START: seq_q <= monitor_pkg::SEQ_WAIT;
            monitor_pkg::SEQ_WAIT: begin
               if (div_done) begin
                  seq_q <= monitor_pkg::SEQ_START;
                  ch_q <= (ch_q == 2'd2) ? 2'd0 : ch_q + 2'd1;
               end
            end
            default: seq_q <= monitor_pkg::SEQ_START;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frac_q[0] <= 11'h000;
         frac_q[1] <= 11'h000;
         frac_q[2] <= 11'h000;
      end else if (seq_q == monitor_pkg::SEQ_WAIT && div_done) begin
         frac_q[ch_q] <= div_frac;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM carrier
   logic [3:0] step_cnt_q;
   logic step_en;
   logic [monitor_pkg::PWM_BITS-1:0] pwm_cnt_q;
   logic [11:0] duty_next;

   assign step_en = (step_cnt_q == 4'(monitor_pkg::PWM_STEP_CYCLES - 1));
   assign duty_next = gain_scale(frac_q[0], pulse_output_gain_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt_q <= 4'h0;
      end else begin
         step_cnt_q <= step_en ? 4'h0 : step_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_cnt_q <= '0;
         duty_q <= 11'h000;
      end else if (step_en) begin
         pwm_cnt_q <= pwm_cnt_q + {{(monitor_pkg::PWM_BITS-1){1'b0}}, 1'b1};
         // Duty only changes at a period start, so no runt pulses appear
         if (pwm_cnt_q == '1) begin
            duty_q <= duty_next[10:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // FM phase accumulator
   logic [15:0] fm_freq;
   logic [34:0] fm_prod;
   logic [31:0] phase_q;

   // Clamping at the maximum makes ten times the maximum the top frequency
   assign fm_freq = (output_frequency > max_frequency_setting_q) ? max_frequency_setting_q :
      output_frequency;
   assign fm_prod = 35'(fm_freq) * 35'(monitor_pkg::FM_INC_K);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= 32'h0000_0000;
      end else if (pulse_output_source_select_q == monitor_pkg::SRC_OUT_FREQ_FM) begin
         phase_q <= phase_q + 32'(fm_prod >> monitor_pkg::FM_INC_SHIFT);
      end else begin
         phase_q <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic [11:0] volt_lvl;
   logic [12:0] volt_sum;
   logic [11:0] curr_lvl;
   logic [12:0] curr_sum;

   assign volt_lvl = span_scale(frac_q[1], voltage_output_gain_q, monitor_pkg::VOLT_SPAN);
   assign volt_sum = 13'(volt_lvl) + 13'(voltage_output_offset_q) * 13'd10;
   assign curr_lvl = span_scale(frac_q[2], current_output_gain_q, monitor_pkg::CURR_SPAN);
   assign curr_sum = 13'(monitor_pkg::CURR_BASE) + 13'(curr_lvl) + 13'(current_output_offset_q) * 13'd10;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_monitor_pin <= 1'b0;
         voltage_monitor_pin <= 11'h000;
         current_monitor_pin <= 12'h000;
      end else begin
         if (pulse_output_source_select_q == monitor_pkg::SRC_OUT_FREQ_FM) begin
            pulse_monitor_pin <= phase_q[31];
         end else begin
            pulse_monitor_pin <= ({1'b0, pwm_cnt_q} < duty_q);
         end
         voltage_monitor_pin <= (volt_sum > 13'(monitor_pkg::VOLT_MAX)) ? monitor_pkg::VOLT_MAX :
            volt_sum[10:0];
         current_monitor_pin <= (curr_sum > 13'(monitor_pkg::CURR_MAX)) ? monitor_pkg::CURR_MAX :
            curr_sum[11:0];
      end
   end
endmodule

// ---- bench/monitor_output_generator_asserts.sv ----
// Port-level assertions for the monitor output generator
`timescale 1ns/100ps
module monitor_output_generator_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pulse_monitor_pin,
   input wire logic [10:0] voltage_monitor_pin,
   input wire logic [11:0] current_monitor_pin
);
   logic [7:0] sel_q, vg_q, vo_q, cg_q, co_q;
   logic [15:0] max_q;
   int quiet_q, hi_q, vfl, cfl, half;
   wire wr = psel && penable && pwrite;
   assign vfl = vo_q * 10;
   assign cfl = (co_q * 10 > 1600) ? 2000 : 400 + co_q * 10;
   // Shortest FM high phase for the set maximum, less sampling slack
   assign half = (max_q == 0) ? 0 : 500000000 / max_q - 3;
   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the settings, so the checks know what the outputs should obey
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= monitor_pkg::RST_PULSE_SEL;
         max_q <= monitor_pkg::RST_MAX_FREQ;
         vg_q <= monitor_pkg::RST_VOLT_GAIN;
         vo_q <= monitor_pkg::RST_VOLT_OFS;
         cg_q <= monitor_pkg::RST_CURR_GAIN;
         co_q <= monitor_pkg::RST_CURR_OFS;
      end else if (wr) begin
         case (paddr)
            monitor_pkg::OFS_PULSE_SEL: sel_q <= pwdata[7:0];
            monitor_pkg::OFS_MAX_FREQ: max_q <= pwdata[15:0];
            monitor_pkg::OFS_VOLT_GAIN: vg_q <= pwdata[7:0];
            monitor_pkg::OFS_CURR_GAIN: cg_q <= pwdata[7:0];
            monitor_pkg::OFS_VOLT_OFS: vo_q <= (pwdata[7:0] > 8'h64) ? 8'h64 : pwdata[7:0];
            monitor_pkg::OFS_CURR_OFS: co_q <= (pwdata[7:0] > 8'hC8) ? 8'hC8 : pwdata[7:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_q <= 0;
         hi_q <= 0;
      end else begin
         quiet_q <= wr ? 0 : ((quiet_q < 1000000) ? quiet_q + 1 : quiet_q);
         hi_q <= pulse_monitor_pin ? hi_q + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_volt_span; voltage_monitor_pin <= monitor_pkg::VOLT_MAX; endproperty
   a_volt_span: assert property (p_volt_span) else $error("voltage level above span");
   property p_curr_span;
      quiet_q >= 3 |-> current_monitor_pin >= monitor_pkg::CURR_BASE && current_monitor_pin <= monitor_pkg::CURR_MAX;
   endproperty
   a_curr_span: assert property (p_curr_span) else $error("current level outside span");
   property p_volt_floor; quiet_q >= 60 |-> voltage_monitor_pin >= vfl; endproperty
   a_volt_floor: assert property (p_volt_floor) else $error("voltage below its offset");
   property p_curr_floor; quiet_q >= 60 |-> current_monitor_pin >= cfl; endproperty
   a_curr_floor: assert property (p_curr_floor) else $error("current below its offset");
   property p_volt_gain0; quiet_q >= 60 && vg_q == 8'h00 |-> voltage_monitor_pin == vfl; endproperty
   a_volt_gain0: assert property (p_volt_gain0) else $error("voltage not offset at zero gain");
   property p_curr_gain0; quiet_q >= 60 && cg_q == 8'h00 |-> current_monitor_pin == cfl; endproperty
   a_curr_gain0: assert property (p_curr_gain0) else $error("current not offset at zero gain");
   // A duty step lasts ten cycles, so no PWM pulse or gap is shorter
   property p_pwm_high;
      sel_q != monitor_pkg::SRC_OUT_FREQ_FM && quiet_q >= 20 && $rose(pulse_monitor_pin) |-> pulse_monitor_pin [*8];
   endproperty
   a_pwm_high: assert property (p_pwm_high) else $error("PWM pulse too short");
   property p_pwm_low;
      sel_q != monitor_pkg::SRC_OUT_FREQ_FM && quiet_q >= 20 && $fell(pulse_monitor_pin) |-> !pulse_monitor_pin [*8];
   endproperty
   a_pwm_low: assert property (p_pwm_low) else $error("PWM gap too short");
   property p_fm_half;
      sel_q == monitor_pkg::SRC_OUT_FREQ_FM && quiet_q > hi_q + 4 && $fell(pulse_monitor_pin) |-> hi_q >= half;
   endproperty
   a_fm_half: assert property (p_fm_half) else $error("FM faster than ten times maximum");
   c_fm: cover property (sel_q == monitor_pkg::SRC_OUT_FREQ_FM && $fell(pulse_monitor_pin));
   c_pwm: cover property (sel_q != monitor_pkg::SRC_OUT_FREQ_FM && $rose(pulse_monitor_pin));
   c_gain0: cover property (quiet_q >= 60 && cg_q == 8'h00);
endmodule
bind monitor_output_generator monitor_output_generator_asserts chk (
   .pclk(pclk),
   .presetn(presetn),
   .paddr(paddr),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .pwdata(pwdata),
   .pulse_monitor_pin(pulse_monitor_pin),
   .voltage_monitor_pin(voltage_monitor_pin),
   .current_monitor_pin(current_monitor_pin)
);

// ---- bench/moving_coil_meter.sv ----
// Far-side meter model: integrates pulse duty and times pulse periods
`timescale 1ns/100ps
module moving_coil_meter (
   input wire logic pclk,
   input wire logic pin,
   input wire logic arm,
   output int high_cycles,
   output bit done,
   output int rise_period,
   output int rises
);
   int win, cyc, last;
   bit pin_q;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      pin_q <= pin;
      // Integrate over exactly one carrier period, like needle inertia
      if (arm) begin
         win <= monitor_pkg::PWM_STEP_CYCLES << monitor_pkg::PWM_BITS;
         high_cycles <= 0;
         done <= 1'b0;
      end else if (win > 0) begin
         win <= win - 1;
         high_cycles <= high_cycles + (pin ? 1 : 0);
         done <= (win == 1);
      end
      // Rise to rise timing for the frequency-coded mode
      if (pin && !pin_q) begin
         rise_period <= cyc - last;
         last <= cyc;
         rises <= rises + 1;
      end
   end
endmodule

// ---- bench/monitor_output_generator_test.sv ----
// Self-checking test of the monitor output generator
`timescale 1ns/100ps
module monitor_output_generator_test;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic arm = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, pulse_monitor_pin, err;
   logic [15:0] output_frequency = 16'h05DC;
   logic [15:0] output_current = 16'h03E8;
   logic [15:0] output_voltage = 16'h02EE;
   logic [15:0] input_power = 16'h00FA;
   logic [15:0] thermal_load = 16'h03E8;
   logic [15:0] ramped_frequency = 16'h08CA;
   logic [10:0] voltage_monitor_pin;
   logic [11:0] current_monitor_pin;
   bit done;
   int high_cycles, rise_period, rises, miscompares, compares, cycles, n;
   // Reset image of registers 0x00..0x20, and the fraction each source gives
   logic [15:0] rst_tab [9] = '{16'h0000, 16'h0080, 16'h1770, 16'h0000, 16'h0000,
      16'h00B4, 16'h0000, 16'h0050, 16'h0000};
   logic [7:0] code [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07};
   int fr [6] = '{256, 512, 768, 128, 1024, 384};
   always #5 pclk = ~pclk;
   monitor_output_generator dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .output_frequency(output_frequency), .output_current(output_current), .output_voltage(output_voltage),
      .input_power(input_power), .thermal_load(thermal_load), .ramped_frequency(ramped_frequency),
      .pulse_monitor_pin(pulse_monitor_pin), .voltage_monitor_pin(voltage_monitor_pin),
      .current_monitor_pin(current_monitor_pin));
   moving_coil_meter meter (.pclk(pclk), .pin(pulse_monitor_pin), .arm(arm), .high_cycles(high_cycles),
      .done(done), .rise_period(rise_period), .rises(rises));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check_val("wait states", 32'h0000_0001, k);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check_val("register", exp, rd);
   endtask
   function automatic int vexp(int f, int g, int o);
      return ((((f * g * 1000) >> 17) + o * 10) > 1000) ? 1000 : ((f * g * 1000) >> 17) + o * 10;
   endfunction
   function automatic int cexp(int f, int g, int o);
      return ((((f * g * 1600) >> 17) + o * 10) > 1600) ? 2000 : 400 + ((f * g * 1600) >> 17) + o * 10;
   endfunction
   task automatic levels(input int v, input int c);
      repeat (80) @(posedge pclk);
      check_val("voltage", v, {21'h0, voltage_monitor_pin});
      check_val("current", c, {20'h0, current_monitor_pin});
   endtask
   // Duty needs a full carrier period to latch, then one period to integrate
   task automatic duty(input int d);
      repeat ((monitor_pkg::PWM_STEP_CYCLES << monitor_pkg::PWM_BITS) + 100) @(posedge pclk);
      arm <= 1'b1;
      @(posedge pclk);
      arm <= 1'b0;
      @(posedge pclk);
      for (int k = 0; k < 11000 && !done; k++) @(posedge pclk);
      check_val("high cycles", d * monitor_pkg::PWM_STEP_CYCLES, high_cycles);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 100000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++) reg_chk(8'(4 * i), {16'h0, rst_tab[i]});
      apb(1'b0, 8'h40, 32'h0000_0000);
      check_val("unmapped error", 32'h0000_0001, {31'h0, err});
      reg_wr(8'h18, 32'h0000_00FF);
      reg_chk(8'h18, 32'h0000_0064);
      reg_wr(8'h20, 32'h0000_00FF);
      reg_chk(8'h20, 32'h0000_00C8);
      levels(1000, 2000);
      reg_wr(8'h18, 32'h0000_0000);
      reg_wr(8'h20, 32'h0000_0000);
      reg_wr(8'h14, 32'h0000_0080);
      reg_wr(8'h1C, 32'h0000_0080);
      for (int i = 0; i < 6; i++) begin
         reg_wr(8'h0C, {24'h0, code[i]});
         reg_wr(8'h10, {24'h0, code[(i + 1) % 6]});
         levels(vexp(fr[i], 128, 0), cexp(fr[(i + 1) % 6], 128, 0));
      end
      reg_wr(8'h0C, 32'h0000_0003);
      reg_wr(8'h10, 32'h0000_0006);
      reg_wr(8'h14, 32'h0000_0000);
      reg_wr(8'h18, 32'h0000_0014);
      reg_wr(8'h1C, 32'h0000_0040);
      reg_wr(8'h20, 32'h0000_001E);
      levels(vexp(0, 0, 20), cexp(1024, 64, 30));
      reg_wr(8'h0C, 32'h0000_0006);
      reg_wr(8'h14, 32'h0000_0040);
      reg_wr(8'h1C, 32'h0000_0000);
      levels(vexp(1024, 64, 20), cexp(1024, 0, 30));
      reg_chk(8'h28, 32'h02BC_02BC);
      reg_wr(8'h00, 32'h0000_0001);
      reg_wr(8'h04, 32'h0000_0020);
      duty(128);
      reg_wr(8'h00, 32'h0000_0006);
      reg_wr(8'h04, 32'h0000_00FF);
      duty(1024);
      reg_chk(8'h24, 32'h0001_0400);
      // Input far above a 500.00 Hz maximum, gain zero: expect 5 kHz at 100 MHz
      reg_wr(8'h08, 32'h0000_C350);
      output_frequency <= 16'hFFFF;
      reg_wr(8'h04, 32'h0000_0000);
      reg_wr(8'h00, 32'h0000_0003);
      n = rises;
      for (int k = 0; k < 45000 && rises < n + 2; k++) @(posedge pclk);
      err = rise_period >= 19998 && rise_period <= 20002;
      check_val("fm period near", 32'h0000_0001, {31'h0, err});
      give_verdict();
   end
endmodule
